// File: logic/t2_regs.svh
// Register indices, field positions, reset values and tick counts of the timer
`ifndef T2_REGS_SVH
`define T2_REGS_SVH

// Register indices; byte address is four times the index
`define T2_IDX_CONTROL 10'h0c8
`define T2_IDX_MODE 10'h0c9
`define T2_IDX_CAP_LOW 10'h0ca
`define T2_IDX_CAP_HIGH 10'h0cb
`define T2_IDX_CNT_LOW 10'h0cc
`define T2_IDX_CNT_HIGH 10'h0cd
`define T2_IDX_AUX 10'h0ce
`define T2_IDX_EXT_FLAGS 10'h0cf

// Control register fields
`define T2_CTL_OVF 7
`define T2_CTL_EXF 6
`define T2_CTL_RXSEL 5
`define T2_CTL_TXSEL 4
`define T2_CTL_EXEN 3
`define T2_CTL_RUN 2
`define T2_CTL_CT 1
`define T2_CTL_CPRL 0

// Mode register fields; hardware-clear bits for ext irq 2..5 sit at 4..7
`define T2_MOD_HC_LSB 4
`define T2_MOD_CAPCLR 3
`define T2_MOD_OE 1
`define T2_MOD_DOWN_COUNT_ENABLE 0

// Auxiliary register fields
`define T2_AUX_SPEED 0
`define T2_AUX_SMODE_LSB 1

// Reset values
`define T2_RST_BYTE 8'h00
`define T2_RST_WORD 16'h0000
`define T2_RST_FLAGS 4'h0

// Clocks per tick
`define T2_PRE_SLOW 4'hc
`define T2_PRE_FAST 4'h4
`define T2_PRE_BAUD 4'h2

`endif

// File: logic/t2_pkg.sv
// Types shared by the timer and its bus
package t2_pkg;

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } t2_apb_req_t;

    // Complete state of the timer
    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] mode;
        logic [7:0] aux;
        logic [15:0] cap;
        logic [15:0] cnt;
        logic [3:0] extFlag;
        logic [2:0] syncCount;
        logic [2:0] syncTrig;
        logic [3:0] pre;
        logic clkOut;
        logic irq;
        logic rxTick;
        logic txTick;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } t2_state_t;

endpackage : t2_pkg

// File: logic/t2_timer.sv
// Sixteen-bit capture/reload/baud timer with APB register slave
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "t2_regs.svh"

module t2_timer
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire t2_pkg::t2_apb_req_t apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic countPin,
    input wire logic trigPin,
    input wire logic timer1Ovf,
    input wire logic [3:0] extIrqEdge,
    input wire logic [3:0] isrEntry,
    output logic [3:0] extIrqFlag,
    output logic timerIrq,
    output logic rxBaudTick,
    output logic txBaudTick,
    output logic clkOut
);
    import t2_pkg::*;

    t2_state_t s_reg;
    t2_state_t s_next;

    // Outputs are plain state bits
    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign extIrqFlag = s_reg.extFlag;
    assign timerIrq = s_reg.irq;
    assign rxBaudTick = s_reg.rxTick;
    assign txBaudTick = s_reg.txTick;
    assign clkOut = s_reg.clkOut;

    // Next-state logic of the whole block
    always_comb
    begin
        // Bus decode
        logic [9:0] idx;
        logic mapped;
        logic setup;
        logic wrEn;
        logic [7:0] wb;
        logic [7:0] rb;

        // Mode and pin edges
        logic baud;
        logic run;
        logic countFall;
        logic trigFall;
        logic trigLevel;

        // Counter control
        logic tick;
        logic [3:0] period;
        logic downMode;
        logic goUp;
        logic ovf;
        logic trig;

        // Flag and output updates
        logic ovfSet;
        logic exfSet;
        logic serialVar;
        logic [3:0] hwClr;
        logic [7:0] newCtl;

        idx = apbReq.paddr[11:2];
        setup = apbReq.psel && !apbReq.penable;
        wb = apbReq.pwdata[7:0];
        rb = 8'h00;
        tick = 1'b0;
        period = `T2_PRE_SLOW;
        ovf = 1'b0;
        // Every local gets a value first, so no path leaves one unset
        mapped = 1'b0;
        wrEn = 1'b0;
        baud = 1'b0;
        run = 1'b0;
        countFall = 1'b0;
        trigFall = 1'b0;
        trigLevel = 1'b1;
        downMode = 1'b0;
        goUp = 1'b1;
        trig = 1'b0;
        ovfSet = 1'b0;
        exfSet = 1'b0;
        serialVar = 1'b0;
        hwClr = 4'h0;
        newCtl = 8'h00;
        s_next = s_reg;

        // Index window is the six timer bytes plus aux and ext flags
        // A refused access still completes with zero wait
        // Decode; unaligned or unknown addresses are refused
        mapped = (apbReq.paddr[1:0] == 2'h0)
            && (idx >= `T2_IDX_CONTROL) && (idx <= `T2_IDX_EXT_FLAGS);
        wrEn = apbReq.psel && apbReq.penable && s_reg.pready && apbReq.pwrite && mapped;

        // Chains reset high, so reset release with the pin high never looks like a fall
        // Cost: three clocks of latency from pin to counter
        // two flops, then a third for the edge
        s_next.syncCount = {s_reg.syncCount[1:0], countPin};
        s_next.syncTrig = {s_reg.syncTrig[1:0], trigPin};
        countFall = s_reg.syncCount[2] && !s_reg.syncCount[1];
        trigFall = s_reg.syncTrig[2] && !s_reg.syncTrig[1];
        trigLevel = s_reg.syncTrig[2];

        baud = s_reg.ctl[`T2_CTL_RXSEL] || s_reg.ctl[`T2_CTL_TXSEL];
        run = s_reg.ctl[`T2_CTL_RUN];

        // baud mode ticks every two clocks
        // prescaled clock or count pin edges
        if (baud)
        begin
            period = `T2_PRE_BAUD;
        end
        else if (s_reg.aux[`T2_AUX_SPEED])
        begin
            period = `T2_PRE_FAST;
        end
        else
        begin
            period = `T2_PRE_SLOW;
        end

        // Prescaler is kept while stopped, so a restart resumes mid-period
        // Counter mode bypasses it; the pin edge is the tick
        // stopped timer neither ticks nor moves its prescaler
        if (run)
        begin
            if (!baud && s_reg.ctl[`T2_CTL_CT])
            begin
                tick = countFall;
            end
            else if (s_reg.pre >= period - 4'h1)
            begin
                s_next.pre = 4'h0;
                tick = 1'b1;
            end
            else
            begin
                s_next.pre = s_reg.pre + 4'h1;
            end
        end

        // Direction comes from the synced pin, never the raw one
        // Capture and baud modes always count up
        // pin low counts down when down-count is enabled in reload mode
        downMode = s_reg.mode[`T2_MOD_DOWN_COUNT_ENABLE] && !s_reg.ctl[`T2_CTL_CPRL] && !baud;
        goUp = !downMode || trigLevel;

        // counter steps; wrap from 0xffff is the overflow
        if (tick)
        begin
            if (goUp)
            begin
                if (s_reg.cnt == 16'hffff)
                begin
                    ovf = 1'b1;
                    // capture bytes serve as reload value
                    if (baud || !s_reg.ctl[`T2_CTL_CPRL])
                    begin
                        s_next.cnt = s_reg.cap;
                    end
                    else
                    begin
                        s_next.cnt = 16'h0000;
                    end
                end
                else
                begin
                    s_next.cnt = s_reg.cnt + 16'h0001;
                end
            end
            else
            begin
                // match with reload value counts as overflow
                if (s_reg.cnt == s_reg.cap)
                begin
                    ovf = 1'b1;
                    s_next.cnt = 16'hffff;
                end
                else
                begin
                    s_next.cnt = s_reg.cnt - 16'h0001;
                end
            end
        end

        // Capture takes the count as it stood before this cycle's tick
        // Auto-clear beats a tick landing on the same edge
        // enabled trigger edge acts only outside baud mode
        trig = trigFall && s_reg.ctl[`T2_CTL_EXEN] && !baud;
        if (trig)
        begin
            if (s_reg.ctl[`T2_CTL_CPRL])
            begin
                // copy count bytes into capture bytes
                s_next.cap = s_reg.cnt;
                if (s_reg.mode[`T2_MOD_CAPCLR])
                begin
                    s_next.cnt = 16'h0000;
                end
            end
            else if (!downMode)
            begin
                s_next.cnt = s_reg.cap;
            end
        end

        // Both flag causes are single-cycle events
        // Set requests merge with software writes further down
        // no hardware set while generating baud clocks
        ovfSet = ovf && !baud;
        // edge, or overflow in down-count mode
        exfSet = trig || (ovf && downMode);

        // Limitation: a tick lost under a count write is not replayed
        // Control and ext flag writes are merged separately below
        // Software writes to data registers win over hardware updates
        if (wrEn)
        begin
            case (idx)
                `T2_IDX_MODE: s_next.mode = wb;
                `T2_IDX_CAP_LOW: s_next.cap[7:0] = wb;
                `T2_IDX_CAP_HIGH: s_next.cap[15:8] = wb;
                `T2_IDX_CNT_LOW: s_next.cnt[7:0] = wb;
                `T2_IDX_CNT_HIGH: s_next.cnt[15:8] = wb;
                `T2_IDX_AUX: s_next.aux = wb;
                default: s_next.aux = s_reg.aux;
            endcase
        end

        // Control register: software value, hardware sets win over clears
        newCtl = (wrEn && idx == `T2_IDX_CONTROL) ? wb : s_reg.ctl;
        newCtl[`T2_CTL_OVF] = newCtl[`T2_CTL_OVF] || ovfSet;
        // external flag stays until software clears it
        newCtl[`T2_CTL_EXF] = newCtl[`T2_CTL_EXF] || exfSet;
        s_next.ctl = newCtl;

        // Registered from the new flag values, so the line changes on the same clock as the flag
        // interrupt follows either flag, including a software set
        s_next.irq = newCtl[`T2_CTL_OVF] || newCtl[`T2_CTL_EXF];

        // Unselected directions pass timer 1 through, one clock late
        // Serial mode low bit (aux bit 1) marks the variable-rate modes
        // receive time base in serial modes 1 and 3
        // transmit time base in serial modes 1 and 3
        serialVar = s_reg.aux[`T2_AUX_SMODE_LSB];
        s_next.rxTick = (serialVar && s_reg.ctl[`T2_CTL_RXSEL]) ? ovf : timer1Ovf;
        s_next.txTick = (serialVar && s_reg.ctl[`T2_CTL_TXSEL]) ? ovf : timer1Ovf;

        // Output runs at half the overflow rate
        // Disabling it parks the output low
        // clock-out toggles per overflow, held low when disabled
        if (!s_reg.mode[`T2_MOD_OE])
        begin
            s_next.clkOut = 1'b0;
        end
        else if (ovf)
        begin
            s_next.clkOut = !s_reg.clkOut;
        end

        // A new edge beats a same-cycle service clear or write
        // Flags without a hardware-clear bit wait for software
        // service entry clears flags whose hardware-clear bit is set
        hwClr = isrEntry & s_reg.mode[`T2_MOD_HC_LSB +: 4];
        if (wrEn && idx == `T2_IDX_EXT_FLAGS)
        begin
            s_next.extFlag = (wb[3:0] & ~hwClr) | extIrqEdge;
        end
        else
        begin
            s_next.extFlag = (s_reg.extFlag & ~hwClr) | extIrqEdge;
        end

        // Upper bytes always read zero
        // Unmapped indices read zero and raise an error
        // Read mux, sampled in the setup cycle
        case (idx)
            `T2_IDX_CONTROL: rb = s_reg.ctl;
            `T2_IDX_MODE: rb = s_reg.mode;
            `T2_IDX_CAP_LOW: rb = s_reg.cap[7:0];
            `T2_IDX_CAP_HIGH: rb = s_reg.cap[15:8];
            `T2_IDX_CNT_LOW: rb = s_reg.cnt[7:0];
            `T2_IDX_CNT_HIGH: rb = s_reg.cnt[15:8];
            `T2_IDX_AUX: rb = s_reg.aux;
            `T2_IDX_EXT_FLAGS: rb = {4'h0, s_reg.extFlag};
            default: rb = 8'h00;
        endcase

        // Back-to-back transfers need no idle cycle between them
        // Error and data clear once the bus goes idle
        // Zero-wait slave: answer registered in setup, seen in access
        s_next.pready = setup;
        if (setup)
        begin
            s_next.pslverr = !mapped;
            s_next.prdata = (mapped && !apbReq.pwrite) ? {24'h000000, rb} : 32'h00000000;
        end
        else if (!apbReq.psel)
        begin
            s_next.pslverr = 1'b0;
            s_next.prdata = 32'h00000000;
        end
    end

    // Reset loads constants only; sync chains idle high
    // One register for the whole state keeps updates atomic
    // State register
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg.ctl <= `T2_RST_BYTE;
            s_reg.mode <= `T2_RST_BYTE;
            s_reg.aux <= `T2_RST_BYTE;
            s_reg.cap <= `T2_RST_WORD;
            s_reg.cnt <= `T2_RST_WORD;
            s_reg.extFlag <= `T2_RST_FLAGS;
            s_reg.syncCount <= 3'h7;
            s_reg.syncTrig <= 3'h7;
            s_reg.pre <= 4'h0;
            s_reg.clkOut <= 1'b0;
            s_reg.irq <= 1'b0;
            s_reg.rxTick <= 1'b0;
            s_reg.txTick <= 1'b0;
            s_reg.prdata <= 32'h00000000;
            s_reg.pready <= 1'b0;
            s_reg.pslverr <= 1'b0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

endmodule : t2_timer

// File: tb/t2_timer_monitor.sv
// Port-level checks on the timer's bus, external interrupt flag 0 and baud ticks
`timescale 1ns/1ps
module t2_timer_monitor
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire t2_pkg::t2_apb_req_t apbReq,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] extIrqEdge,
    input wire logic [3:0] extIrqFlag,
    input wire logic rxBaudTick,
    input wire logic txBaudTick
);
    import t2_pkg::*;
    logic setup;
    logic badAddr;
    // Setup phase and decode; unaligned or outside the block is refused
    assign setup = apbReq.psel && !apbReq.penable;
    assign badAddr = apbReq.paddr[1:0] != 2'h0 || apbReq.paddr[11:2] < 10'h0c8
        || apbReq.paddr[11:2] > 10'h0cf;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_setup_ready; setup |=> pready; endproperty
    a_setup_ready: assert property (p_setup_ready)
        else $error("no ready after setup");
    property p_ready_cause; pready |-> $past(setup); endproperty
    a_ready_cause: assert property (p_ready_cause)
        else $error("ready without setup");
    property p_err_bad; setup && badAddr |=> pslverr && prdata == 32'h0; endproperty
    a_err_bad: assert property (p_err_bad)
        else $error("bad address not refused");
    property p_err_ok; setup && !badAddr |=> !pslverr && prdata[31:8] == 24'h0; endproperty
    a_err_ok: assert property (p_err_ok)
        else $error("good address refused");
    property p_irq_set; extIrqEdge[0] |=> extIrqFlag[0]; endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("edge did not set flag");
    property p_irq_cause;
        $rose(extIrqFlag[0]) |-> $past(extIrqEdge[0])
            || $past(pready && apbReq.psel && apbReq.pwrite);
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("flag rose without cause");
    property p_rx_pulse; rxBaudTick |=> !rxBaudTick; endproperty
    a_rx_pulse: assert property (p_rx_pulse)
        else $error("receive tick too long");
    property p_tx_pulse; txBaudTick |=> !txBaudTick; endproperty
    a_tx_pulse: assert property (p_tx_pulse)
        else $error("transmit tick too long");
endmodule : t2_timer_monitor

// File: tb/t2_pins_model.sv
// Far-side pins: trigger and count pin fall on request, both idle high
`timescale 1ns/1ps
module t2_pins_model
(
    input wire logic clk_sys,
    input wire logic fallReq,
    input wire logic countReq,
    input wire logic trigHold,
    output logic trigPin,
    output logic countPin
);
    logic [2:0] lowCnt = 3'h0;
    logic [2:0] cntLow = 3'h0;
    always @(posedge clk_sys)
    begin
        if (countReq)
            cntLow <= 3'h4;
        else if (cntLow != 3'h0)
            cntLow <= cntLow - 3'h1;
    end
    always @(posedge clk_sys)
    begin
        if (fallReq)
            lowCnt <= 3'h4;
        else if (lowCnt != 3'h0)
            lowCnt <= lowCnt - 3'h1;
    end
    // hold keeps the trigger low for down counting
    assign trigPin = (lowCnt == 3'h0) && !trigHold;
    assign countPin = cntLow == 3'h0; // Idle high
endmodule : t2_pins_model

// File: tb/t2_timer_bench.sv
// Self-checking bench for the timer over APB
`timescale 1ns/1ps
`include "t2_regs.svh"
module t2_timer_bench;
    import t2_pkg::*;
    localparam logic [9:0] iCtl = `T2_IDX_CONTROL;
    localparam logic [9:0] iMod = `T2_IDX_MODE;
    localparam logic [9:0] iCapL = `T2_IDX_CAP_LOW;
    localparam logic [9:0] iCapH = `T2_IDX_CAP_HIGH;
    localparam logic [9:0] iCntL = `T2_IDX_CNT_LOW;
    localparam logic [9:0] iCntH = `T2_IDX_CNT_HIGH;
    localparam logic [9:0] iAux = `T2_IDX_AUX;
    logic clk_sys;
    logic rst_n;
    t2_apb_req_t apbReq;
    logic [31:0] prdata;
    logic pready, pslverr, countPin, trigPin, timer1Ovf, fallReq, countReq, trigHold;
    logic [3:0] extIrqEdge, isrEntry, extIrqFlag;
    logic timerIrq, rxBaudTick, txBaudTick, clkOut;
    int n_errors = 0;
    int n_checks = 0;

    t2_timer t2_timer_inst (.clk_sys(clk_sys), .rst_n(rst_n), .apbReq(apbReq),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .countPin(countPin),
        .trigPin(trigPin), .timer1Ovf(timer1Ovf), .extIrqEdge(extIrqEdge),
        .isrEntry(isrEntry), .extIrqFlag(extIrqFlag), .timerIrq(timerIrq),
        .rxBaudTick(rxBaudTick), .txBaudTick(txBaudTick), .clkOut(clkOut));
    t2_pins_model t2_pins_model_inst (.clk_sys(clk_sys), .fallReq(fallReq),
        .countReq(countReq), .trigHold(trigHold),
        .trigPin(trigPin), .countPin(countPin));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // One transfer; an idle edge first so signals never change twice a step
    task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
        output logic [7:0] r, output logic e);
        @(posedge clk_sys);
        apbReq <= '{1'b1, 1'b0, w, a, {24'h0, d}};
        @(posedge clk_sys);
        apbReq.penable <= 1'b1;
        // Ready, data and error are taken at the rising edge that sees ready
        do @(posedge clk_sys); while (pready !== 1'b1);
        r = prdata[7:0];
        e = pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [9:0] i, input logic [7:0] d);
        logic [7:0] r;
        logic e;
        apb(1'b1, {i, 2'b00}, d, r, e);
    endtask : wr

    task automatic rd(input logic [9:0] i, input logic [7:0] exp);
        logic [7:0] r;
        logic e;
        apb(1'b0, {i, 2'b00}, 8'h00, r, e);
        chk({e, r}, {1'b0, exp});
    endtask : rd

    task automatic load(input logic [15:0] c, input logic [15:0] n);
        wr(iCapL, c[7:0]);
        wr(iCapH, c[15:8]);
        wr(iCntL, n[7:0]);
        wr(iCntH, n[15:8]);
    endtask : load

    task automatic trig;
        @(posedge clk_sys) fallReq <= 1'b1;
        @(posedge clk_sys) fallReq <= 1'b0;
        repeat (10) @(posedge clk_sys);
    endtask : trig

    task automatic pulse_count;
        @(posedge clk_sys) countReq <= 1'b1;
        @(posedge clk_sys) countReq <= 1'b0;
        repeat (10) @(posedge clk_sys);
    endtask : pulse_count

    task automatic test_reset;
        for (int i = 0; i < 8; i++)
            rd(10'(iCtl + i), 8'h00);
    endtask : test_reset

    task automatic test_reload;
        logic [7:0] r;
        logic e;
        wr(iAux, 8'h01);
        load(16'hfffe, 16'hfffe);
        wr(iCtl, 8'h04);
        repeat (16) @(posedge clk_sys);
        rd(iCntH, 8'hff);
        rd(iCtl, 8'h84);
        chk(timerIrq, 1'b1);
        wr(iCtl, 8'h80);
        apb(1'b0, {iCntL, 2'b00}, 8'h00, r, e);
        // Seven ticks' time: a running count would show the other byte
        repeat (25) @(posedge clk_sys);
        rd(iCntL, r);
        wr(iCtl, 8'h00);
        rd(iCtl, 8'h00);
    endtask : test_reload

    task automatic test_capture;
        wr(iAux, 8'h00);
        wr(iMod, 8'h08);
        load(16'h0000, 16'h1234);
        wr(iCtl, 8'h09);
        trig();
        rd(iCapL, 8'h34);
        rd(iCapH, 8'h12);
        rd(iCntL, 8'h00);
        rd(iCntH, 8'h00);
        rd(iCtl, 8'h49);
        chk(timerIrq, 1'b1);
        wr(iCtl, 8'h01);
        wr(iCntL, 8'h55);
        trig();
        rd(iCapL, 8'h34);
        rd(iCtl, 8'h01);
    endtask : test_capture

    task automatic test_baud;
        int nRx = 0;
        int nTx = 0;
        wr(iMod, 8'h00);
        wr(iAux, 8'h02);
        load(16'hfffe, 16'hfffe);
        // Capture select set: baud mode must still reload
        wr(iCtl, 8'h25);
        @(posedge clk_sys) timer1Ovf <= 1'b1;
        @(posedge clk_sys) timer1Ovf <= 1'b0;
        repeat (40)
        begin
            @(negedge clk_sys);
            nRx += int'(rxBaudTick);
            nTx += int'(txBaudTick);
        end
        chk(nRx >= 9 && nRx <= 11, 1'b1);
        chk(16'(nTx), 16'h1);
        rd(iCtl, 8'h25);
        wr(iCtl, 8'h00);
    endtask : test_baud

    task automatic test_misc;
        logic [7:0] r;
        logic e;
        apb(1'b0, 12'h400, 8'h00, r, e);
        chk({e, r}, 9'h100);
        apb(1'b1, 12'h321, 8'hff, r, e);
        chk(e, 1'b1);
        wr(iMod, 8'h10);
        @(posedge clk_sys) extIrqEdge <= 4'h9;
        @(posedge clk_sys) extIrqEdge <= 4'h0;
        @(negedge clk_sys) chk(extIrqFlag, 4'h9);
        @(posedge clk_sys) isrEntry <= 4'hf;
        @(posedge clk_sys) isrEntry <= 4'h0;
        @(negedge clk_sys) chk(extIrqFlag, 4'h8);
    endtask : test_misc

    // Down count to a match, clock out, then counter mode and edge reload
    task automatic test_down;
        @(posedge clk_sys) trigHold <= 1'b1;
        wr(iAux, 8'h01);
        wr(iMod, 8'h03);
        load(16'h0010, 16'h0012);
        wr(iCtl, 8'h04);
        repeat (20) @(posedge clk_sys);
        rd(iCtl, 8'hc4);
        rd(iCntH, 8'hff);
        chk(clkOut, 1'b1);
        wr(iCtl, 8'h00);
        @(posedge clk_sys) trigHold <= 1'b0;
        wr(iMod, 8'h00);
        load(16'h1200, 16'h0005);
        chk(clkOut, 1'b0);
        wr(iCtl, 8'h0e);
        repeat (3) pulse_count();
        rd(iCntL, 8'h08);
        trig();
        rd(iCntH, 8'h12);
        rd(iCntL, 8'h00);
        rd(iCtl, 8'h4e);
        wr(iCtl, 8'h00);
    endtask : test_down

    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    // Clock at 100 ns
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // Hang guard, far beyond the expected run
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        n_errors++;
        complete_run();
    end

    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        apbReq = '0;
        timer1Ovf = 1'b0;
        fallReq = 1'b0;
        countReq = 1'b0;
        trigHold = 1'b0;
        extIrqEdge = 4'h0;
        isrEntry = 4'h0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        test_reset();
        $display("reset test done");
        test_reload();
        $display("reload test done");
        test_capture();
        $display("capture test done");
        test_baud();
        $display("baud test done");
        test_misc();
        $display("bus and irq test done");
        test_down();
        $display("down and counter test done");
        complete_run();
    end
endmodule : t2_timer_bench

bind t2_timer t2_timer_monitor t2_timer_monitor_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extIrqEdge(extIrqEdge), .extIrqFlag(extIrqFlag), .rxBaudTick(rxBaudTick),
    .txBaudTick(txBaudTick));
